// ===== hdl/ssr_status_summary.sv
// Purpose: read-only fault summary byte, summary word and output_voltage_summary status
// Assumes: all condition inputs are produced by logic on clk_sys
// Notes: reads are command-code addressed, one reply a cycle after request
`timescale 1ns/100ps
module ssr_status_summary #(
    parameter int VW = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    // command-code read port from the serial bus engine
    input wire logic rdReq,
    input wire logic [7:0] rdCmd,
    output ssr_pkg::ssr_rd_rsp_t rdRsp_q,
    // converter state
    input wire logic outputDelivering,
    input wire logic outputEnabled,
    input wire ssr_pkg::ssr_output_voltage_summary_cond_t voutCond,
    input wire ssr_pkg::ssr_detail_t detail,
    input wire logic clearFaults,
    // setpoint write check
    input wire logic setpointWrite,
    input wire logic [VW-1:0] setpointValue,
    input wire logic [VW-1:0] setpointCeiling,
    // power-good thresholds
    input wire logic [VW-1:0] voutMeas,
    input wire logic [VW-1:0] pgOnThreshold,
    input wire logic [VW-1:0] uvWarnLimit,
    // status views
    output logic powerGood_q,
    output logic [15:0] summaryWord_q,
    output logic [7:0] voutStatus_q
);
    import ssr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic anySet(input logic [7:0] v);
        anySet = |v;
    endfunction

    function automatic logic [1:0] replyLen(input logic [7:0] cmd);
        unique case (cmd)
            CMD_SUMMARY_BYTE: replyLen = LEN_BYTE;
            CMD_SUMMARY_WORD: replyLen = LEN_WORD;
            CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS: replyLen = LEN_BYTE;
            default: replyLen = LEN_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // output-voltage detail flags

    logic [7:0] voutSet;
    logic [7:0] voutFlags;
    logic setpointBad;
    logic voutPg;

    // floor compare is on the raw code; exponent must match FRAC_BITS
    always_comb begin
        setpointBad = setpointWrite &&
            ((setpointValue > setpointCeiling) ||
             (setpointValue < VW'(SETPOINT_FLOOR_CODE)));
    end

    always_comb begin
        voutSet = '0;
        voutSet[VS_OV_FAULT] = voutCond.ovFault;
        // a warning is suppressed while its fault is active
        voutSet[VS_OV_WARN] = voutCond.ovWarn && !voutCond.ovFault;
        voutSet[VS_UV_WARN] = voutCond.uvWarn && !voutCond.uvFault;
        voutSet[VS_UV_FAULT] = voutCond.uvFault;
        voutSet[VS_SETPOINT] = setpointBad;
        voutSet = voutSet & MASK_OUTPUT_VOLTAGE_SUMMARY_STATUS;
    end

    ssr_sticky_bits #(
        .W(8)
    ) u_output_voltage_summary_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(voutSet),
        .clr(clearFaults),
        .flags_q(voutFlags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // power-good

    ssr_power_good #(
        .VW(VW)
    ) u_pgood (
        .clk_sys(clk_sys),
        .rst(rst),
        .outputEnabled(outputEnabled),
        .voutMeas(voutMeas),
        .pgOnThreshold(pgOnThreshold),
        .uvWarnLimit(uvWarnLimit),
        .powerGood_q(voutPg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // summary storage: one low byte shared by both summary commands

    logic [7:0] summaryLow_d;
    logic [7:0] summaryLow_q;
    logic [7:0] summaryHigh_d;
    logic [7:0] summaryHigh_q;
    logic [15:0] wordView;

    // summary bits follow their detail bits, no latching of their own
    always_comb begin
        summaryLow_d = '0;
        summaryLow_d[SB_OFF] = !outputDelivering;
        summaryLow_d[SB_OV_FAULT] = voutFlags[VS_OV_FAULT];
        summaryLow_d[SB_OC_FAULT] = detail.output_current_summary[OUTPUT_OVERCURRENT_FAULT_BIT];
        summaryLow_d[SB_VIN_UV] = detail.inputV[INPUT_UV_FAULT_BIT];
        summaryLow_d[SB_TEMP] = anySet(detail.temp);
        summaryLow_d[SB_CML] = anySet(detail.comm_memory_logic_fault);
        summaryLow_d = summaryLow_d & MASK_SUMMARY_BYTE;
    end

    always_comb begin
        summaryHigh_d = '0;
        summaryHigh_d[SW_OUTPUT_VOLTAGE_SUMMARY - 8] = anySet(voutFlags);
        summaryHigh_d[SW_OUTPUT_CURRENT_SUMMARY - 8] = anySet(detail.output_current_summary);
        summaryHigh_d[SW_INPUT - 8] = anySet(detail.inputV);
        summaryHigh_d[SW_VENDOR - 8] = anySet(detail.vendor);
        summaryHigh_d[SW_PG_BAD - 8] = !voutPg;
        summaryHigh_d[SW_OTHER - 8] = anySet(voutFlags) ||
            anySet(detail.output_current_summary) || anySet(detail.inputV) ||
            anySet(detail.temp) || anySet(detail.comm_memory_logic_fault) ||
            anySet(detail.vendor);
        summaryHigh_d = summaryHigh_d & MASK_SUMMARY_WORD[15:8];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            summaryLow_q <= RST_SUMMARY_BYTE;
        end else begin
            summaryLow_q <= summaryLow_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            summaryHigh_q <= RST_SUMMARY_WORD[15:8];
        end else begin
            summaryHigh_q <= summaryHigh_d;
        end
    end

    // both commands read summaryLow_q, so they can never disagree
    assign wordView = {summaryHigh_q, summaryLow_q};

    ////////////////////////////////////////////////////////////////////////////
    // command-code read port

    logic [15:0] rdData_d;

    always_comb begin
        rdData_d = '0;
        unique case (rdCmd)
            CMD_SUMMARY_BYTE: begin
                rdData_d = {8'h00, summaryLow_q};
            end
            CMD_SUMMARY_WORD: begin
                rdData_d = wordView;
            end
            CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS: begin
                rdData_d = {8'h00, voutFlags};
            end
            default: begin
                rdData_d = '0;
            end
        endcase
    end

    // registers are read-only; a reply is given for every request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdRsp_q <= '0;
        end else begin
            rdRsp_q.valid <= rdReq;
            rdRsp_q.unsupported <= rdReq && (replyLen(rdCmd) == LEN_NONE);
            rdRsp_q.len <= rdReq ? replyLen(rdCmd) : LEN_NONE;
            rdRsp_q.data <= rdReq ? rdData_d : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status views

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powerGood_q <= 1'b0;
        end else begin
            powerGood_q <= voutPg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            summaryWord_q <= RST_SUMMARY_WORD;
        end else begin
            summaryWord_q <= wordView;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            voutStatus_q <= RST_OUTPUT_VOLTAGE_SUMMARY_STATUS;
        end else begin
            voutStatus_q <= voutFlags;
        end
    end
endmodule

// ===== common/ssr_pkg.sv
// Purpose: constants and types for the fault status summary bank
// Assumes: voltages arrive as unsigned linear codes with a fixed exponent
// Notes: command codes double as register offsets
//
// Overview of operation
// - one-byte read-only summary at 78h, reset 00h, no faults.
// - two-byte read-only summary word at 79h, reset 0000h.
// - word low byte is the very same storage as the summary byte.
// - bit 6 set whenever output power is not delivered, any reason.
// - bit 5 reports an output overvoltage fault.
// - bit 4 reports an output overcurrent fault.
// - bit 3 reports an input undervoltage fault.
// - bit 2 reports a temperature fault or warning.
// - bit 1 reports a communication, memory or logic fault.
// - word bit 15 reports an output-voltage fault or warning.
// - word bit 14 reports an output-current fault or warning.
// - word bit 13 reports an input-voltage fault or warning.
// - word bit 12 reports a vendor-defined fault or warning.
// - word bit 11 set while power-good reports output not good.
// - word bit 9 set when any detail status bit is set.
// - output-voltage status at 7Ah, reset zero, bit 7 overvoltage fault.
// - output-voltage status bit 4 flags an undervoltage fault.
// - warnings on bits 6 and 5 never set while matching fault occurs.
// - bit 3 set on setpoint write above ceiling or below 0.1 V.
// - power-good rises above on threshold, falls below undervolt warn limit.
package ssr_pkg;

    localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS = 8'h7A;

    localparam logic [7:0] RST_SUMMARY_BYTE = 8'h00;
    localparam logic [15:0] RST_SUMMARY_WORD = 16'h0000;
    localparam logic [7:0] RST_OUTPUT_VOLTAGE_SUMMARY_STATUS = 8'h00;

    // summary bit positions
    localparam int SB_OFF = 6;
    localparam int SB_OV_FAULT = 5;
    localparam int SB_OC_FAULT = 4;
    localparam int SB_VIN_UV = 3;
    localparam int SB_TEMP = 2;
    localparam int SB_CML = 1;
    localparam int SW_OUTPUT_VOLTAGE_SUMMARY = 15;
    localparam int SW_OUTPUT_CURRENT_SUMMARY = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_VENDOR = 12;
    localparam int SW_PG_BAD = 11;
    localparam int SW_OTHER = 9;

    // output-voltage status bit positions
    localparam int VS_OV_FAULT = 7;
    localparam int VS_OV_WARN = 6;
    localparam int VS_UV_WARN = 5;
    localparam int VS_UV_FAULT = 4;
    localparam int VS_SETPOINT = 3;

    // detail bit positions used by the summary
    localparam int OUTPUT_OVERCURRENT_FAULT_BIT = 7;
    localparam int INPUT_UV_FAULT_BIT = 4;

    // readable-bit masks, everything else reads zero
    localparam logic [7:0] MASK_SUMMARY_BYTE = 8'h7E;
    localparam logic [15:0] MASK_SUMMARY_WORD = 16'hFA7E;
    localparam logic [7:0] MASK_OUTPUT_VOLTAGE_SUMMARY_STATUS = 8'hF8;

    // reply lengths in bytes
    localparam logic [1:0] LEN_NONE = 2'h0;
    localparam logic [1:0] LEN_BYTE = 2'h1;
    localparam logic [1:0] LEN_WORD = 2'h2;

    // setpoint floor, 0.1 V as an unsigned code with FRAC_BITS fraction bits
    localparam int SETPOINT_FLOOR_MV = 100;
    localparam int FRAC_BITS = 12;
    localparam logic [15:0] SETPOINT_FLOOR_CODE =
        16'((SETPOINT_FLOOR_MV * (1 << FRAC_BITS) + 999) / 1000);

    typedef struct packed {
        logic [7:0] output_current_summary;
        logic [7:0] inputV;
        logic [7:0] temp;
        logic [7:0] comm_memory_logic_fault;
        logic [7:0] vendor;
    } ssr_detail_t;

    typedef struct packed {
        logic ovFault;
        logic ovWarn;
        logic uvWarn;
        logic uvFault;
    } ssr_output_voltage_summary_cond_t;

    typedef struct packed {
        logic valid;
        logic unsupported;
        logic [1:0] len;
        logic [15:0] data;
    } ssr_rd_rsp_t;

endpackage

// ===== hdl/ssr_sticky_bits.sv
// Purpose: vector of sticky flags with a common clear
// Assumes: set and clear come from logic on clk_sys
// Notes: a set in the cycle of a clear survives
`timescale 1ns/100ps
module ssr_sticky_bits #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic clr,
    output logic [W-1:0] flags_q
);
    logic [W-1:0] flags_d;

    // set wins over clear so an event in the clearing cycle is kept
    always_comb begin
        flags_d = (flags_q & ~{W{clr}}) | set;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule

// ===== hdl/ssr_power_good.sv
// Purpose: power-good indication with hysteresis
// Assumes: voltage and thresholds share one unsigned code scale
// Notes: held low while the output is disabled
`timescale 1ns/100ps
module ssr_power_good #(
    parameter int VW = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic outputEnabled,
    input wire logic [VW-1:0] voutMeas,
    input wire logic [VW-1:0] pgOnThreshold,
    input wire logic [VW-1:0] uvWarnLimit,
    output logic powerGood_q
);
    // between the two thresholds the previous state is kept
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powerGood_q <= 1'b0;
        end else if (!outputEnabled) begin
            powerGood_q <= 1'b0;
        end else if (voutMeas > pgOnThreshold) begin
            powerGood_q <= 1'b1;
        end else if (voutMeas < uvWarnLimit) begin
            powerGood_q <= 1'b0;
        end
    end
endmodule

// ===== bench/ssr_checker.sv
// Purpose: port checker for the fault status summary bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module, watches its ports only
`timescale 1ns/100ps
module ssr_checker #(
    parameter int VW = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rdReq,
    input wire logic [7:0] rdCmd,
    input wire ssr_pkg::ssr_rd_rsp_t rdRsp_q,
    input wire logic outputDelivering,
    input wire logic outputEnabled,
    input wire ssr_pkg::ssr_output_voltage_summary_cond_t voutCond,
    input wire logic [VW-1:0] voutMeas,
    input wire logic [VW-1:0] uvWarnLimit,
    input wire logic powerGood_q,
    input wire logic [15:0] summaryWord_q,
    input wire logic [7:0] voutStatus_q
);
    import ssr_pkg::*;
    // summary view needs a few edges after reset before it tracks power-good
    logic [1:0] age_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    sequence s_ovHeld;
        voutCond.ovFault ##1 (voutCond.ovFault && !voutStatus_q[VS_OV_WARN]);
    endsequence
    sequence s_uvHeld;
        voutCond.uvFault ##1 (voutCond.uvFault && !voutStatus_q[VS_UV_WARN]);
    endsequence
    property p_idle;
        !rdReq |=> rdRsp_q == '0;
    endproperty
    property p_byte;
        rdReq && rdCmd == CMD_SUMMARY_BYTE |=> rdRsp_q.valid && rdRsp_q.len == LEN_BYTE
            && rdRsp_q.data == {8'h00, summaryWord_q[7:0]};
    endproperty
    property p_word;
        rdReq && rdCmd == CMD_SUMMARY_WORD |=> rdRsp_q.valid && rdRsp_q.len == LEN_WORD
            && rdRsp_q.data == summaryWord_q;
    endproperty
    property p_output_voltage_summary;
        rdReq && rdCmd == CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS |=> rdRsp_q.len == LEN_BYTE
            && rdRsp_q.data == {8'h00, voutStatus_q};
    endproperty
    property p_unused;
        (summaryWord_q & 16'h0581) == 16'h0000 && (voutStatus_q & 8'h07) == 8'h00;
    endproperty
    property p_off;
        !outputDelivering [*4] |-> summaryWord_q[SB_OFF];
    endproperty
    property p_pgBad;
        age_q == 2'h3 |-> summaryWord_q[SW_PG_BAD] == !$past(powerGood_q);
    endproperty
    // powerGood_q is a registered copy of the internal flag, so it drops two edges late
    property p_pgOff;
        !outputEnabled |-> ##2 !powerGood_q;
    endproperty
    property p_pgFall;
        voutMeas < uvWarnLimit |-> ##2 !powerGood_q;
    endproperty
    property p_ovWarn;
        s_ovHeld |-> ##2 !voutStatus_q[VS_OV_WARN];
    endproperty
    property p_uvWarn;
        s_uvHeld |-> ##2 !voutStatus_q[VS_UV_WARN];
    endproperty
    a_idle: assert property (p_idle) else $error("reply without request");
    a_byte: assert property (p_byte) else $error("summary byte reply wrong");
    a_word: assert property (p_word) else $error("summary word reply wrong");
    a_output_voltage_summary: assert property (p_output_voltage_summary) else $error("output_voltage_summary status reply wrong");
    a_unused: assert property (p_unused) else $error("unused bit set");
    a_off: assert property (p_off) else $error("off bit clear");
    a_pgBad: assert property (p_pgBad) else $error("pg bad bit wrong");
    a_pgOff: assert property (p_pgOff) else $error("pg while disabled");
    a_pgFall: assert property (p_pgFall) else $error("pg below limit");
    a_ovWarn: assert property (p_ovWarn) else $error("ov warning with fault");
    a_uvWarn: assert property (p_uvWarn) else $error("uv warning with fault");
endmodule
bind ssr_status_summary ssr_checker #(.VW(VW)) ssr_checker_i (.*);

// ===== bench/ssr_host_model.sv
// Purpose: bus host issuing command-code reads
// Assumes: requests launched 1 ns after a clock edge
// Notes: idle cycles before a request model a slow host
`timescale 1ns/100ps
module ssr_host_model (
    input wire logic clk_sys,
    input wire ssr_pkg::ssr_rd_rsp_t rdRsp_q,
    output logic rdReq,
    output logic [7:0] rdCmd
);
    import ssr_pkg::*;
    initial begin
        rdReq = 1'b0;
        rdCmd = 8'h00;
    end
    // callers read in any order; the bench mixes summary byte, summary word and output-voltage status reads
    task automatic read(input logic [7:0] cmd, input int gap, output ssr_rd_rsp_t rsp);
        // one edge always passes with the request low, so launch delay stays 1 ns
        repeat (gap + 1) @(posedge clk_sys);
        #1;
        rdReq = 1'b1;
        rdCmd = cmd;
        @(posedge clk_sys);
        #1;
        rdReq = 1'b0;
        // code lines show a changed value once released
        rdCmd = ~cmd;
        rsp = rdRsp_q;
    endtask
endmodule

// ===== bench/ssr_status_summary_tb.sv
// Purpose: self-checking bench for the fault status summary bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected words are built from the documented bit positions
`timescale 1ns/100ps
module ssr_status_summary_tb;
    import ssr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic rdReq, outputDelivering, outputEnabled, clearFaults, setpointWrite, powerGood_q;
    logic [7:0] rdCmd, voutStatus_q;
    logic [15:0] setpointValue, setpointCeiling, voutMeas, pgOnThreshold, uvWarnLimit;
    logic [15:0] summaryWord_q;
    ssr_rd_rsp_t rdRsp_q, rsp;
    ssr_output_voltage_summary_cond_t voutCond;
    ssr_detail_t detail;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    logic [39:0] dv [6] = '{40'h8000000000, 40'h0010000000, 40'h0080000000,
        40'h0000400000, 40'h0000008000, 40'h0000000001};
    logic [15:0] ew [6] = '{16'h4210, 16'h2208, 16'h2200, 16'h0204, 16'h0202, 16'h1200};
    logic [15:0] sv [4] = '{16'h1001, 16'h1000, 16'h019A, 16'h0199};
    logic [7:0] bad [3] = '{8'h77, 8'h7B, 8'hFF};
    always #4 clk_sys = ~clk_sys;
    ssr_status_summary #(.VW(16)) ssr_status_summary_i (.*);
    ssr_host_model ssr_host_model_i (.*);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        ssr_host_model_i.read(cmd, 0, rsp);
        chk(rsp, {2'b10, (cmd == CMD_SUMMARY_WORD) ? LEN_WORD : LEN_BYTE, exp});
    endtask
    task automatic clr();
        clearFaults = 1'b1;
        settle(1);
        clearFaults = 1'b0;
        settle(3);
    endtask
    task automatic pulse(input logic [3:0] c);
        voutCond = c;
        settle(1);
        voutCond = 4'h0;
        settle(4);
    endtask
    task automatic t_pg();
        outputEnabled = 1'b1;
        outputDelivering = 1'b1;
        voutMeas = 16'h0F00;
        // 2 ms settling is not modelled; power-good is judged after a few edges
        settle(6);
        rd(CMD_SUMMARY_WORD, 16'h0000);
        voutMeas = 16'h0D00;
        settle(4);
        rd(CMD_SUMMARY_WORD, 16'h0000);
        voutMeas = 16'h0B00;
        settle(4);
        rd(CMD_SUMMARY_WORD, 16'h0800);
        voutMeas = 16'h0D00;
        settle(4);
        rd(CMD_SUMMARY_WORD, 16'h0800);
        voutMeas = 16'h0F00;
        settle(4);
        chk({19'h0, powerGood_q}, 20'h00001);
        // a disabled output forces power-good low whatever the voltage
        outputEnabled = 1'b0;
        settle(4);
        chk({19'h0, powerGood_q}, 20'h00000);
        rd(CMD_SUMMARY_WORD, 16'h0800);
        outputEnabled = 1'b1;
        settle(4);
        chk({19'h0, powerGood_q}, 20'h00001);
    endtask
    task automatic t_detail();
        for (int i = 0; i < 6; i++) begin
            detail = dv[i];
            settle(4);
            rd(CMD_SUMMARY_WORD, ew[i]);
            rd(CMD_SUMMARY_BYTE, {8'h00, ew[i][7:0]});
        end
        detail = '0;
    endtask
    task automatic t_output_voltage_summary();
        pulse(4'b1000);
        rd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0080);
        rd(CMD_SUMMARY_WORD, 16'h8220);
        clr();
        voutCond = 4'b1111;
        settle(4);
        pulse(4'b0001);
        rd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0090);
        clr();
        pulse(4'b0110);
        rd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0060);
        rd(CMD_SUMMARY_WORD, 16'h8200);
        clr();
        rd(CMD_SUMMARY_WORD, 16'h0000);
    endtask
    task automatic t_setpoint();
        setpointCeiling = 16'h1000;
        for (int i = 0; i < 4; i++) begin
            setpointValue = sv[i];
            setpointWrite = 1'b1;
            settle(1);
            setpointWrite = 1'b0;
            settle(3);
            rd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, (i == 0 || i == 3) ? 16'h0008 : 16'h0000);
            clr();
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        outputDelivering = 1'b0;
        outputEnabled = 1'b0;
        voutCond = '0;
        detail = '0;
        clearFaults = 1'b0;
        setpointWrite = 1'b0;
        setpointValue = 16'h0800;
        setpointCeiling = 16'h1000;
        voutMeas = 16'h0000;
        pgOnThreshold = 16'h0E00;
        uvWarnLimit = 16'h0C00;
        settle(2);
        chk({4'h0, summaryWord_q}, 20'h00000);
        chk({12'h0, voutStatus_q}, 20'h00000);
        settle(1);
        rst = 1'b0;
        settle(4);
        rd(CMD_SUMMARY_BYTE, 16'h0040);
        rd(CMD_SUMMARY_WORD, 16'h0840);
        t_pg();
        t_detail();
        t_output_voltage_summary();
        t_setpoint();
        for (int i = 0; i < 3; i++) begin
            ssr_host_model_i.read(bad[i], i, rsp);
            chk(rsp, {2'b11, LEN_NONE, 16'h0000});
        end
        print_verdict();
    end
endmodule
